// file: core/fnc_defines.svh
// Purpose: Constants for the fieldbus node config and status block
// Assumes: 200 MHz clock, byte-addressed registers
// Notes: Definitions only
`ifndef FNC_DEFINES_SVH
`define FNC_DEFINES_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define FNC_CLK_HZ 200000000
// 1 s cycle half period, ms
`define FNC_FLASH1_HALF_MS 500
// 2 s cycle half period, ms
`define FNC_FLASH2_HALF_MS 1000
// Fast flash half period, ms
`define FNC_FAST_HALF_MS 250
`define FNC_MS_CYCLES(ms) ((`FNC_CLK_HZ / 1000) * (ms))
// Settle cycles before capture
`define FNC_CAPTURE_WAIT 8'h10

// ------------------------------------------------------------
// Settings switch bits (index = switch - 1)
// ------------------------------------------------------------
`define FNC_SW_SIZE_A 0
`define FNC_SW_SIZE_B 1
`define FNC_SW_HOLD 3
`define FNC_SW_BLANK 6
`define FNC_SW_HUND 7

// ------------------------------------------------------------
// Node address limits
// ------------------------------------------------------------
`define FNC_ADDR_MAX 7'h7D

// ------------------------------------------------------------
// Register map, byte offsets
// ------------------------------------------------------------
`define FNC_REG_CFG 8'h00
`define FNC_REG_CTRL 8'h04
`define FNC_REG_STAT 8'h08
`define FNC_REG_IRQ_ST 8'h0C
`define FNC_REG_IRQ_EN 8'h10
`define FNC_REG_IRQ_CLR 8'h14
`define FNC_REG_LEDS 8'h18

// Control register fields
`define FNC_CTRL_DIAG 0
`define FNC_CTRL_HOLD_EN 1
`define FNC_CTRL_RST 2'h3

`endif

// file: core/fnc_pkg.sv
// Purpose: Types for the fieldbus node config and status block
// Assumes: Constants come from fnc_defines.svh
// Notes: Holds enums and structs only
package fnc_pkg;

    // LED colour drive
    typedef struct packed {
        logic red;
        logic green;
    } fnc_led_s;

    // Master link condition
    typedef enum logic [2:0] {
        FNC_LINK_OK = 3'b000,
        FNC_LINK_NO_DATA = 3'b001,
        FNC_LINK_CFG_MISMATCH = 3'b010,
        FNC_LINK_BAUD_BAD_ADDR = 3'b011,
        FNC_LINK_MASTER_LOST = 3'b100
    } fnc_link_e;

    // Power-up capture sequence
    typedef enum logic [1:0] {
        FNC_ST_WAIT = 2'b00,
        FNC_ST_RUN = 2'b01
    } fnc_state_e;

    // Captured configuration
    typedef struct packed {
        logic [6:0] node_addr;
        logic [2:0] out_bytes;
        logic hold_sw;
        logic blank;
    } fnc_cfg_s;

    // Unit health inputs
    typedef struct packed {
        logic io_diag_err;
        logic valve_count_err;
        logic valve_wire_err;
        logic io_comm_err;
        logic unit_fail;
        logic ctrl_pwr_ok;
        logic out_pwr_ok;
        logic master_diag_err;
    } fnc_health_s;

endpackage

// file: core/fnc_node_status.sv
// Purpose: Switch capture, valve output gating and status LED patterns
// Assumes: Switches and health flags are asynchronous
// Notes: Patterns use counters on the 200 MHz clock
//
// Operation
// - Capture switches once after power-up only
// - Untouched switches give address zero, 32 outputs
// - Address is hundreds, tens and units switches
// - Address zero or above 125 lights fault LEDs
// - Size switches pick 4, 3, 2, 1 bytes
// - Comm error clears outputs unless hold chosen
// - Hold switch acts only when control bit enables
// - Switch seven blanks all status LEDs
// - Module LED green steady, flashing on I/O error
// - Red flashing for valve faults with diagnostics
// - Alternate on I/O comm fail, red on failure
// - Control power LED green, red if abnormal with diagnostics
// - Output power LED green, red or dark
// - Fault LEDs dark when link is healthy
// - Link up with diagnostics: only system fault
// - No master data: bus fault steady red
// - Config mismatch: system red, bus flashing
// - Bus fault flashes 1 s or 2 s cycle
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/1ps
`include "fnc_defines.svh"

module fnc_node_status
    import fnc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    // Front-panel switches (asynchronous)
    input wire logic [3:0] addr_ones_i,
    input wire logic [3:0] addr_tens_i,
    input wire logic [7:0] settings_i,
    // Unit health and link condition (asynchronous)
    input wire logic [7:0] health_i,
    input wire logic [2:0] link_i,
    // Valve data from the protocol engine
    input wire logic [31:0] valve_data_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Outputs
    output logic [31:0] valve_o,
    output logic [6:0] node_addr_o,
    output logic [2:0] out_bytes_o,
    output fnc_led_s module_status_led_o,
    output fnc_led_s control_power_led_o,
    output fnc_led_s output_power_led_o,
    output logic system_fault_led_o,
    output logic bus_fault_led_o,
    output logic irq_o
);

    // ------------------------------------------------------------
    // Timing constants
    // ------------------------------------------------------------
    localparam int unsigned FAST_CYC = `FNC_MS_CYCLES(`FNC_FAST_HALF_MS);
    localparam int unsigned F1_CYC = `FNC_MS_CYCLES(`FNC_FLASH1_HALF_MS);
    localparam int unsigned F2_CYC = `FNC_MS_CYCLES(`FNC_FLASH2_HALF_MS);

    // ------------------------------------------------------------
    // State of the block apart from the input synchronisers
    // ------------------------------------------------------------
    typedef struct packed {
        fnc_state_e st;          // Capture sequence
        logic [7:0] wait_cnt;    // Settle counter
        fnc_cfg_s cfg;           // Captured switches
        logic [27:0] cnt_fast;   // Fast flash divider
        logic [27:0] cnt_f1;     // 1 s cycle divider
        logic [28:0] cnt_f2;     // 2 s cycle divider
        logic ph_fast;           // Fast phase
        logic ph_f1;             // 1 s phase
        logic ph_f2;             // 2 s phase
        logic [1:0] ctrl;        // Control register
        logic [3:0] irq_st;      // Sticky events
        logic [3:0] irq_en;      // Event enables
        logic [3:0] ev_prev;     // Event levels last cycle
        logic [31:0] valve;      // Valve output register
        logic [31:0] vd1; // Valve data, one cycle late
        logic [31:0] vd2; // Valve data, two cycles late
        logic [31:0] rdata;      // Bus read data
        logic ack;               // Bus acknowledge
        fnc_led_s st_led;        // Module status LED
        fnc_led_s cp_led;        // Control power LED
        fnc_led_s op_led;        // Output power LED
        logic sf;                // System fault LED
        logic bf;                // Bus fault LED
    } fnc_regs_s;

    fnc_regs_s s_q;
    fnc_regs_s s_d;

    // ------------------------------------------------------------
    // Two-flop synchronisers for asynchronous inputs
    // ------------------------------------------------------------
    localparam int SYNC_W = 4 + 4 + 8 + 8 + 3;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;

    // Only stage two is read; no reset, capture waits far longer
    always_ff @(posedge clk_i) begin
        sync1_q <= {addr_ones_i, addr_tens_i, settings_i, health_i,
            link_i};
        sync2_q <= sync1_q;
    end

    logic [3:0] ones_s;
    logic [3:0] tens_s;
    logic [7:0] set_s;
    fnc_health_s hl;
    fnc_link_e link;
    assign {ones_s, tens_s, set_s} = sync2_q[SYNC_W-1:11];
    assign hl = fnc_health_s'(sync2_q[10:3]);
    assign link = fnc_link_e'(sync2_q[2:0]);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    // Size switches to byte count, off-off is the largest
    function automatic logic [2:0] size_bytes(input logic a, input logic b);
        case ({a, b})
            2'b00: size_bytes = 3'h4;
            2'b01: size_bytes = 3'h3;
            2'b10: size_bytes = 3'h2;
            default: size_bytes = 3'h1;
        endcase
    endfunction

    // Byte-lane 0 write merge
    function automatic logic [3:0] wr_bits(input logic [3:0] old,
        input logic [31:0] d, input logic [3:0] sel);
        wr_bits = sel[0] ? d[3:0] : old;
    endfunction

    // ------------------------------------------------------------
    // Derived conditions
    // ------------------------------------------------------------
    logic addr_err;
    logic diag;
    logic comm_bad;
    logic [3:0] ev_now;
    logic wb_req;

    // Out-of-range address is a fault only once captured
    assign addr_err = (s_q.st == FNC_ST_RUN) &&
        ((s_q.cfg.node_addr == 7'h00) ||
         (s_q.cfg.node_addr > `FNC_ADDR_MAX));
    assign diag = s_q.ctrl[`FNC_CTRL_DIAG];
    assign comm_bad = (link != FNC_LINK_OK) || addr_err;
    assign ev_now = {comm_bad, s_q.sf, s_q.bf, addr_err};
    assign wb_req = wb_cyc_i && wb_stb_i && !s_q.ack;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] addr_full;
        logic [3:0] rise;
        fnc_led_s st_led;
        logic sf;
        logic bf;
        addr_full = 8'h00;
        rise = 4'h0;
        st_led = '0;
        sf = 1'b0;
        bf = 1'b0;
        s_d = s_q;

        // Capture once after power-up, then freeze
        case (s_q.st)
            FNC_ST_WAIT: begin
                s_d.wait_cnt = s_q.wait_cnt + 8'h01;
                if (s_q.wait_cnt == `FNC_CAPTURE_WAIT) begin
                    // Hundreds from switch 8 plus decimal digits
                    addr_full = (set_s[`FNC_SW_HUND] ? 8'h64 : 8'h00)
                        + {1'b0, tens_s, 3'b000} + {3'b000, tens_s, 1'b0}
                        + {4'h0, ones_s};
                    // Saturate so values 128 to 255 still flag an error
                    s_d.cfg.node_addr = addr_full[7] ? 7'h7F
                        : addr_full[6:0];
                    s_d.cfg.out_bytes = size_bytes(set_s[`FNC_SW_SIZE_A],
                        set_s[`FNC_SW_SIZE_B]);
                    s_d.cfg.hold_sw = set_s[`FNC_SW_HOLD];
                    s_d.cfg.blank = set_s[`FNC_SW_BLANK];
                    s_d.st = FNC_ST_RUN;
                end
            end
            // Later switch moves are ignored
            FNC_ST_RUN: s_d.st = FNC_ST_RUN;
            default: s_d.st = FNC_ST_WAIT;
        endcase

        // Flash dividers with equal on and off phases
        if (s_q.cnt_fast == 28'(FAST_CYC - 1)) begin
            s_d.cnt_fast = '0;
            s_d.ph_fast = !s_q.ph_fast;
        end else begin
            s_d.cnt_fast = s_q.cnt_fast + 28'h1;
        end
        if (s_q.cnt_f1 == 28'(F1_CYC - 1)) begin
            s_d.cnt_f1 = '0;
            s_d.ph_f1 = !s_q.ph_f1;
        end else begin
            s_d.cnt_f1 = s_q.cnt_f1 + 28'h1;
        end
        if (s_q.cnt_f2 == 29'(F2_CYC - 1)) begin
            s_d.cnt_f2 = '0;
            s_d.ph_f2 = !s_q.ph_f2;
        end else begin
            s_d.cnt_f2 = s_q.cnt_f2 + 29'h1;
        end

        // Valve outputs: clear or hold on link loss; data waits two
        // cycles to meet its synced link, so no dead image slips out
        s_d.vd1 = valve_data_i;
        s_d.vd2 = s_q.vd1;
        if (s_q.st != FNC_ST_RUN) begin
            s_d.valve = '0;
        end else if (!comm_bad) begin
            s_d.valve = s_q.vd2 & (32'hFFFF_FFFF >>
                {3'h4 - s_q.cfg.out_bytes, 3'b000});
        end else if (s_q.cfg.hold_sw &&
                     s_q.ctrl[`FNC_CTRL_HOLD_EN]) begin
            s_d.valve = s_q.valve;
        end else begin
            s_d.valve = '0;
        end

        // Module status LED, worst condition first
        if (hl.unit_fail) begin
            st_led = '{red: 1'b1, green: 1'b0};
        end else if (hl.io_comm_err) begin
            st_led = '{red: s_q.ph_fast, green: !s_q.ph_fast};
        end else if (diag && (hl.valve_count_err || hl.valve_wire_err)) begin
            st_led = '{red: s_q.ph_fast, green: 1'b0};
        end else if (hl.io_diag_err) begin
            st_led = '{red: 1'b0, green: s_q.ph_fast};
        end else begin
            st_led = '{red: 1'b0, green: 1'b1};
        end
        // Dark when the control supply is down and diagnostics are off
        if (!hl.ctrl_pwr_ok && !diag) begin
            st_led = '0;
        end

        // Fault LEDs from the link condition
        if (addr_err) begin
            sf = 1'b1;
            bf = 1'b1;
        end else begin
            case (link)
                FNC_LINK_OK: begin
                    sf = hl.master_diag_err;
                    bf = 1'b0;
                end
                FNC_LINK_NO_DATA: bf = 1'b1;
                FNC_LINK_CFG_MISMATCH: begin
                    sf = 1'b1;
                    bf = s_q.ph_fast;
                end
                FNC_LINK_BAUD_BAD_ADDR: bf = s_q.ph_f1;
                FNC_LINK_MASTER_LOST: bf = s_q.ph_f2;
                default: bf = 1'b1; // Unknown code: no data
            endcase
        end

        // LED registers, then blanked by switch 7
        s_d.st_led = st_led;
        s_d.cp_led = '{red: !hl.ctrl_pwr_ok && diag,
            green: hl.ctrl_pwr_ok};
        s_d.op_led = '{red: !hl.out_pwr_ok && diag,
            green: hl.out_pwr_ok};
        s_d.sf = sf;
        s_d.bf = bf;
        if (s_q.cfg.blank) begin
            {s_d.st_led, s_d.cp_led, s_d.op_led, s_d.sf, s_d.bf} = '0;
        end
        // Interrupt events on rising levels; set wins over clear
        s_d.ev_prev = ev_now;
        rise = ev_now & ~s_q.ev_prev;

        // Wishbone slave, ack registered one cycle after the request
        s_d.ack = wb_req;
        s_d.rdata = '0;
        if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
                `FNC_REG_CFG: s_d.rdata = {20'h0, s_q.cfg.hold_sw,
                    s_q.cfg.out_bytes, 1'b0, s_q.cfg.node_addr};
                `FNC_REG_CTRL: s_d.rdata = {30'h0, s_q.ctrl};
                `FNC_REG_STAT: s_d.rdata = {24'h0, s_q.st == FNC_ST_RUN,
                    addr_err, s_q.cfg.blank, link, s_q.sf, s_q.bf};
                `FNC_REG_IRQ_ST: s_d.rdata = {28'h0, s_q.irq_st};
                `FNC_REG_IRQ_EN: s_d.rdata = {28'h0, s_q.irq_en};
                `FNC_REG_LEDS: s_d.rdata = {26'h0, s_q.st_led,
                    s_q.cp_led, s_q.op_led};
                default: s_d.rdata = '0; // Unmapped reads zero
            endcase
        end
        if (wb_req && wb_we_i) begin
            case (wb_adr_i)
                `FNC_REG_CTRL: s_d.ctrl = 2'(wr_bits({2'b00, s_q.ctrl},
                    wb_dat_i, wb_sel_i));
                `FNC_REG_IRQ_EN: s_d.irq_en = wr_bits(s_q.irq_en,
                    wb_dat_i, wb_sel_i);
                `FNC_REG_IRQ_CLR: begin
                    if (wb_sel_i[0]) begin
                        s_d.irq_st = s_q.irq_st & ~wb_dat_i[3:0];
                    end
                end
                default: ; // Read-only or unmapped: write dropped
            endcase
        end
        s_d.irq_st = s_d.irq_st | rise;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.st <= FNC_ST_WAIT;
            s_q.cfg.out_bytes <= 3'h4;
            s_q.ctrl <= `FNC_CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_dat_o = s_q.rdata;
    assign wb_ack_o = s_q.ack;
    assign valve_o = s_q.valve;
    assign node_addr_o = s_q.cfg.node_addr;
    assign out_bytes_o = s_q.cfg.out_bytes;
    assign module_status_led_o = s_q.st_led;
    assign control_power_led_o = s_q.cp_led;
    assign output_power_led_o = s_q.op_led;
    assign system_fault_led_o = s_q.sf;
    assign bus_fault_led_o = s_q.bf;
    assign irq_o = |(s_q.irq_st & s_q.irq_en);

endmodule

// file: verif/fnc_node_status_monitor.sv
// Purpose: Port checks of the node status block
// Assumes: Bound into the design, one clock
// Notes: Waits 63 cycles, past the capture window
`timescale 1ns/1ps
module fnc_node_status_monitor
    import fnc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] health_i,
    input wire logic [2:0] link_i,
    input wire logic [31:0] valve_data_i,
    input wire logic [31:0] valve_o,
    input wire logic [6:0] node_addr_o,
    input wire logic [2:0] out_bytes_o,
    input wire fnc_led_s module_status_led_o,
    input wire fnc_led_s control_power_led_o,
    input wire fnc_led_s output_power_led_o,
    input wire logic system_fault_led_o,
    input wire logic bus_fault_led_o
);
    // ------------------------------
    // Helpers
    // ------------------------------
    logic [5:0] age_q; // Cycles since reset, saturating
    logic settled; // Capture long finished
    logic lit; // Not blanked; power LED is the proxy
    logic ok_addr; // Captured address in the legal range
    logic [31:0] mask; // Valve bits the captured size allows

    // Age counter: skips capture and $past warm-up
    always_ff @(posedge clk_i) begin
        if (rst_i) age_q <= 6'h00;
        else if (age_q != 6'h3F) age_q <= age_q + 6'h01;
    end

    // Derived conditions
    always_comb begin
        settled = age_q == 6'h3F;
        lit = settled && (control_power_led_o != 2'b00);
        ok_addr = (node_addr_o != 7'h00) && (node_addr_o <= 7'h7D);
        mask = 32'hFFFFFFFF >> (32 - 8 * int'(out_bytes_o));
    end

    // ------------------------------
    // Assertions
    // ------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    valve_size_a:
    assert property (settled |-> (valve_o & ~mask) == 32'h0)
        else $error("valve bit beyond size");
    valve_pass_a:
    assert property ((settled && ok_addr && link_i == 3'h0) [*6]
        |-> valve_o == ($past(valve_data_i, 3) & mask))
        else $error("valve image not passed");
    valve_hold_a:
    assert property ((settled && link_i != 3'h0) [*6]
        |-> (valve_o == 32'h0 || $stable(valve_o)))
        else $error("valve not cleared or held");
    fault_dark_a:
    assert property ((lit && ok_addr && link_i == 3'h0 && health_i == 8'h06)
        [*6] |-> !system_fault_led_o && !bus_fault_led_o)
        else $error("fault LED on healthy link");
    diag_sf_a:
    assert property ((lit && ok_addr && link_i == 3'h0 && health_i == 8'h07)
        [*6] |-> system_fault_led_o && !bus_fault_led_o)
        else $error("diag error not system fault only");
    no_data_a:
    assert property ((lit && link_i == 3'h1) [*6] |-> bus_fault_led_o)
        else $error("bus fault dark, no data");
    addr_err_a:
    assert property ((lit && !ok_addr) [*4]
        |-> system_fault_led_o && bus_fault_led_o)
        else $error("bad address not on both faults");
    unit_fail_a:
    assert property ((lit && health_i == 8'h0E) [*6]
        |-> module_status_led_o == 2'b10)
        else $error("unit failure not red");
    pwr_green_a:
    assert property ((lit && health_i[2] && health_i[1]) [*6]
        |-> control_power_led_o == 2'b01 && output_power_led_o == 2'b01)
        else $error("good supplies not green");

    // Main scenarios seen
    cover property (lit && link_i == 3'h1 ##1 bus_fault_led_o);
    cover property (lit && !ok_addr);
    cover property (settled && link_i != 3'h0 && valve_o != 32'h0);
endmodule

// file: verif/fnc_master_model.sv
// Purpose: Fieldbus master stand-in
// Assumes: Driven by the bench, node clock
// Notes: Dead link shows inverted stale data
`timescale 1ns/1ps
module fnc_master_model
    import fnc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] cmd_link_i,
    input wire logic [31:0] cmd_data_i,
    output logic [2:0] link_o,
    output logic [31:0] valve_data_o
);
    logic [31:0] good_q; // Last image sent on a good link

    // A dead link shows neither fresh nor held data
    always_ff @(posedge clk_i) begin
        link_o <= cmd_link_i;
        if (rst_i) good_q <= 32'h00000000;
        else if (cmd_link_i == FNC_LINK_OK) good_q <= cmd_data_i;
        valve_data_o <= (cmd_link_i == FNC_LINK_OK) ? cmd_data_i : ~good_q;
    end
endmodule

// file: verif/fnc_node_status_test.sv
// Purpose: Bench for the node status block
// Assumes: Classic Wishbone master
// Notes: Flashing is too slow to judge
`timescale 1ns/1ps
`include "fnc_defines.svh"
module fnc_node_status_test
    import fnc_pkg::*;
;
    // ------------------------------
    // Stimulus and wiring
    // ------------------------------
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] ones = 4'h0; // Units switch
    logic [3:0] tens = 4'h0; // Tens switch
    logic [7:0] sett = 8'h00; // Settings bank
    logic [7:0] health = 8'h06; // Both supplies good
    logic [2:0] cmd_link = 3'h0; // Link state to the model
    logic [31:0] cmd_data = 32'hA5C39E7F; // Valve image
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat; // Word taken at the ack edge
    logic [2:0] link;
    logic [31:0] vdata, dat_o, valve;
    logic ack, sf, bf, irq;
    logic [6:0] naddr;
    logic [2:0] nbytes;
    fnc_led_s st_led, cp_led, op_led;
    int fail_count = 0;
    int samples_checked = 0;

    // Clock
    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    fnc_master_model i_fnc_master_model (.clk_i(clk_i), .rst_i(rst_i),
        .cmd_link_i(cmd_link), .cmd_data_i(cmd_data), .link_o(link),
        .valve_data_o(vdata));
    // Byte lanes tied: only lane 0 is ever decoded
    fnc_node_status i_fnc_node_status (.clk_i(clk_i), .rst_i(rst_i),
        .addr_ones_i(ones), .addr_tens_i(tens), .settings_i(sett),
        .health_i(health), .link_i(link), .valve_data_i(vdata),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .valve_o(valve), .node_addr_o(naddr), .out_bytes_o(nbytes),
        .module_status_led_o(st_led), .control_power_led_o(cp_led),
        .output_power_led_o(op_led), .system_fault_led_o(sf),
        .bus_fault_led_o(bf), .irq_o(irq));

    // ------------------------------
    // Shared tasks
    // ------------------------------
    task automatic check(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // One classic cycle; held until ack is sampled high
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        rdat = dat_o;
        if (ack !== 1'b1) begin
            fail_count++;
            give_verdict();
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    // Reset stands in for power-off
    task automatic power_up(input logic [7:0] s, input logic [3:0] t,
            input logic [3:0] o);
        @(posedge clk_i);
        rst_i <= 1'b1;
        sett <= s;
        tens <= t;
        ones <= o;
        health <= 8'h06;
        cmd_link <= FNC_LINK_OK;
        wait_n(3);
        rst_i <= 1'b0;
        wait_n(40);
    endtask

    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic t_switches();
        logic [7:0] s [4] = '{8'h00, 8'h02, 8'h81, 8'h83};
        logic [3:0] t [4] = '{4'h0, 4'h9, 4'h2, 4'h2};
        logic [3:0] o [4] = '{4'h0, 4'h9, 4'h5, 4'h6};
        int a, b;
        logic e;
        for (int i = 0; i < 4; i++) begin
            power_up(s[i], t[i], o[i]);
            a = 100 * s[i][7] + 10 * t[i] + o[i];
            b = 4 - 2 * s[i][0] - s[i][1];
            e = (a == 0) || (a >= 126);
            check("address", 32'(naddr), 32'(a));
            check("bytes", 32'(nbytes), 32'(b));
            check("sf", 32'(sf), 32'(e));
            check("bf", 32'(bf), 32'(e));
            check("valves", valve, e ? 32'h0 :
                cmd_data & (32'hFFFFFFFF >> (32 - 8 * b)));
            check("module led", 32'(st_led), 32'h1);
            check("power leds", 32'({cp_led, op_led}), 32'h5);
            wb(1'b0, `FNC_REG_CFG, 32'h0);
            check("cfg", rdat, 32'({s[i][3], 3'(b), 1'b0, 7'(a)}));
        end
        // Later switch moves ignored
        sett <= 8'h00;
        ones <= 4'h1;
        wait_n(40);
        check("kept address", 32'(naddr), 32'd126);
        check("kept bytes", 32'(nbytes), 32'h1);
    endtask

    task automatic t_regs();
        power_up(8'h88, 4'h2, 4'h5);
        wb(1'b0, `FNC_REG_CTRL, 32'h0);
        check("ctrl reset", rdat, 32'h3);
        wb(1'b0, 8'h1C, 32'h0);
        check("unmapped", rdat, 32'h0);
        wb(1'b1, `FNC_REG_CFG, 32'h0);
        wb(1'b0, `FNC_REG_CFG, 32'h0);
        check("cfg ro", rdat, 32'hC7D);
        // Hold on: last good image kept
        cmd_link <= FNC_LINK_NO_DATA;
        wait_n(10);
        check("held", valve, cmd_data);
        check("bf steady", 32'(bf), 32'h1);
        wb(1'b1, `FNC_REG_CTRL, 32'h1);
        wait_n(4);
        check("hold off", valve, 32'h0);
    endtask

    task automatic t_clear();
        power_up(8'h80, 4'h2, 4'h5);
        for (int c = 1; c < 5; c++) begin
            cmd_link <= 3'(c);
            wait_n(10);
            check("cleared", valve, 32'h0);
            if (c == 2) check("sf cfg", 32'(sf), 32'h1);
            cmd_link <= FNC_LINK_OK;
            wait_n(10);
            check("restored", valve, cmd_data);
        end
    endtask

    task automatic t_health();
        health <= 8'h07;
        wait_n(8);
        check("sf diag", 32'({sf, bf}), 32'h2);
        health <= 8'h0E;
        wait_n(8);
        check("unit fail", 32'(st_led), 32'h2);
        health <= 8'h02;
        wait_n(8);
        check("ctrl pwr", 32'(cp_led), 32'h2);
        health <= 8'h04;
        wait_n(8);
        check("out pwr red", 32'(op_led), 32'h2);
        wb(1'b1, `FNC_REG_CTRL, 32'h0);
        wait_n(8);
        check("out pwr dark", 32'(op_led), 32'h0);
    endtask

    task automatic t_irq();
        power_up(8'h80, 4'h2, 4'h5);
        wb(1'b1, `FNC_REG_IRQ_EN, 32'h2);
        cmd_link <= FNC_LINK_NO_DATA;
        wait_n(10);
        check("irq on", 32'(irq), 32'h1);
        wb(1'b1, `FNC_REG_IRQ_EN, 32'h0);
        check("irq masked", 32'(irq), 32'h0);
        cmd_link <= FNC_LINK_OK;
        wait_n(10);
        wb(1'b0, `FNC_REG_IRQ_ST, 32'h0);
        check("sticky", rdat & 32'h2, 32'h2);
        wb(1'b1, `FNC_REG_IRQ_CLR, 32'hF);
        wb(1'b0, `FNC_REG_IRQ_ST, 32'h0);
        check("cleared", rdat, 32'h0);
    endtask

    task automatic t_blank();
        power_up(8'hC0, 4'h2, 4'h5);
        check("blank", 32'({st_led, cp_led, op_led, sf, bf}), 32'h0);
    endtask

    // Main sequence
    initial begin
        t_switches();
        t_regs();
        t_clear();
        t_health();
        t_irq();
        t_blank();
        give_verdict();
    end
endmodule

bind fnc_node_status fnc_node_status_monitor i_fnc_node_status_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .health_i(health_i), .link_i(link_i),
    .valve_data_i(valve_data_i), .valve_o(valve_o),
    .node_addr_o(node_addr_o), .out_bytes_o(out_bytes_o),
    .module_status_led_o(module_status_led_o),
    .control_power_led_o(control_power_led_o),
    .output_power_led_o(output_power_led_o),
    .system_fault_led_o(system_fault_led_o),
    .bus_fault_led_o(bus_fault_led_o));
